// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import adccal_pkg::*;
;
	logic                      clk_sys, rstn, reg_wr, reg_rd, conv_start;
	logic                      raw_valid, samp_valid, cmp_high;
	logic [7:0]                reg_addr, reg_wdata, reg_rdata;
	logic [ADCCAL_DW-1:0]      raw_data, cal_trial, corr_data;
	logic [3:0]                chan_code;
	logic [ADCCAL_CH_EN_W-1:0] chan_en;
	logic                      cal_run, cal_gain, corr_valid, adc_busy, irq;
	int                        errors = 0;
	int                        num_checks = 0;

	adccal_ctrl dut (
		.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
		.raw_valid(raw_valid), .raw_data(raw_data), .samp_valid(samp_valid),
		.cmp_high(cmp_high), .chan_code(chan_code), .chan_en(chan_en), .cal_run(cal_run),
		.cal_gain(cal_gain), .cal_trial(cal_trial), .corr_valid(corr_valid),
		.corr_data(corr_data), .adc_busy(adc_busy), .irq(irq)
	);

	// Free-running core clock
	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Compare and count
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string w);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, w, seen, exp);
		end
	endtask : chk

	// One-cycle register write, entered and left at a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask : wr

	// Register read, data taken mid-cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
		logic [7:0] d;
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		@(negedge clk_sys);
		d = reg_rdata;
		chk({4'h0, d}, {4'h0, e}, w);
		@(posedge clk_sys);
	endtask : rc

	// Reset values, read-only places, unmapped address
	task automatic t_reset();
		rc(ADCCAL_CTRL_ADDR, 8'h00, "ctrl reset");
		rc(ADCCAL_GAIN_HI_ADDR, 8'h08, "gain reset");
		rc(ADCCAL_OFS_LO_ADDR, 8'h00, "ofs reset");
		wr(ADCCAL_CTRL_ADDR, 8'h80);
		rc(ADCCAL_CTRL_ADDR, 8'h00, "busy written");
		wr(ADCCAL_OFS_LO_ADDR, 8'hff);
		rc(ADCCAL_OFS_LO_ADDR, 8'h00, "ofs written");
		wr(8'h10, 8'h5a);
		rc(8'h10, 8'h00, "unmapped");
	endtask : t_reset

	// Every channel code through the decoder
	task automatic t_chan();
		logic [10:0] e;
		for (int c = 0; c < 16; c++) begin
			chan_code <= c[3:0];
			e = (c <= 5) ? 11'h1 << c : (c >= 8 && c <= 12) ? 11'h1 << (c - 2) : 11'h0;
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk({1'h0, chan_en}, {1'h0, e}, "chan");
			@(posedge clk_sys);
		end
	endtask : t_chan

	// Full calibration, comparator steering the trial towards tgt
	task automatic t_cal(input logic typ, input logic [1:0] avg, input int n,
			input logic [11:0] tgt);
		int k;
		wr(ADCCAL_CTRL_ADDR, {2'h0, avg, 2'h1, typ, 1'h1});
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk({9'h0, cal_run, adc_busy, cal_gain}, {9'h0, 2'h3, typ}, "launch");
		chk(cal_trial, ADCCAL_TRIAL_TOP, "first trial");
		@(posedge clk_sys);
		rc(ADCCAL_CTRL_ADDR, {2'h2, avg, 2'h1, typ, 1'h1}, "ctrl running");
		for (k = 0; k < 12 * n; k++) begin
			samp_valid <= 1'h1;
			cmp_high <= ~tgt[11 - k / n];
			if (k == 12 * n - 1) begin
				@(negedge clk_sys);
				chk({11'h0, cal_run}, 12'h1, "ended early");
			end
			@(posedge clk_sys);
		end
		samp_valid <= 1'h0;
		// Short grace for the closing cycle
		@(negedge clk_sys);
		for (k = 0; k < 3 && cal_run !== 1'h0; k++)
			@(negedge clk_sys);
		chk({10'h0, cal_run, adc_busy}, 12'h0, "cal end");
		chk(cal_trial, tgt, "final trial");
		@(posedge clk_sys);
		rc(ADCCAL_CTRL_ADDR, {2'h0, avg, 2'h1, typ, 1'h0}, "ctrl done");
		rc(typ ? ADCCAL_GAIN_LO_ADDR : ADCCAL_OFS_LO_ADDR, tgt[7:0], "coef lo");
		rc(typ ? ADCCAL_GAIN_HI_ADDR : ADCCAL_OFS_HI_ADDR, {4'h0, tgt[11:8]}, "coef hi");
	endtask : t_cal

	// Completion event raised, masked and cleared
	task automatic t_irq();
		rc(ADCCAL_STAT_ADDR, 8'h01, "status");
		wr(ADCCAL_MASK_ADDR, 8'h01);
		@(negedge clk_sys);
		chk({11'h0, irq}, 12'h1, "irq on");
		@(posedge clk_sys);
		wr(ADCCAL_MASK_ADDR, 8'h02);
		@(negedge clk_sys);
		chk({11'h0, irq}, 12'h0, "irq masked");
		@(posedge clk_sys);
		wr(ADCCAL_MASK_ADDR, 8'h01);
		@(posedge clk_sys);
		wr(ADCCAL_STAT_ADDR, 8'h01);
		@(negedge clk_sys);
		chk({11'h0, irq}, 12'h0, "irq cleared");
		@(posedge clk_sys);
		rc(ADCCAL_STAT_ADDR, 8'h00, "status clear");
	endtask : t_irq

	// One conversion under the given bypass settings
	task automatic t_conv(input logic [7:0] cfg, input logic [11:0] raw,
			input logic [11:0] exp);
		wr(ADCCAL_CTRL_ADDR, cfg);
		conv_start <= 1'h1;
		@(posedge clk_sys);
		conv_start <= 1'h0;
		@(negedge clk_sys);
		chk({11'h0, adc_busy}, 12'h1, "conv busy");
		@(posedge clk_sys);
		rc(ADCCAL_CTRL_ADDR, cfg | 8'h80, "ctrl converting");
		raw_valid <= 1'h1;
		raw_data <= raw;
		@(posedge clk_sys);
		raw_valid <= 1'h0;
		@(negedge clk_sys);
		chk({10'h0, corr_valid, adc_busy}, 12'h2, "conv end");
		chk(corr_data, exp, "corrected");
		@(posedge clk_sys);
		rc(ADCCAL_STAT_ADDR, 8'h03, "conv event");
	endtask : t_conv

	// Verdict and end of run
	task automatic tally_and_finish();
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		{rstn, reg_wr, reg_rd, conv_start, raw_valid, samp_valid, cmp_high} = 7'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		raw_data = 12'h000;
		chan_code = 4'h0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		t_reset();
		t_chan();
		t_cal(1'h0, 2'h0, 15, 12'h005);
		t_irq();
		t_cal(1'h1, 2'h2, 31, 12'h400);
		t_cal(1'h1, 2'h3, 63, 12'hc00);
		t_cal(1'h0, 2'h1, 1, 12'h010);
		t_conv(8'h00, 12'h200, 12'h2e8);
		t_conv(8'h08, 12'h200, 12'h300);
		t_conv(8'h40, 12'h200, 12'h1f0);
		t_conv(8'h48, 12'h200, 12'h200);
		t_conv(8'h00, 12'hfff, 12'hfff);
		t_conv(8'h00, 12'h008, 12'h000);
		tally_and_finish();
	end

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire

// File: design/adccal_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Busy flag sits in control bit 7, read-only, high during conversion or calibration.
// - Busy drops by itself when the cycle that raised it has finished.
// - Bit 6 low applies the gain coefficient to results; high bypasses it.
// - Bit 3 low applies the offset coefficient to results; high bypasses it.
// - Bits 5:4 pick readings per bit decision: 15, 1, 31 or 63.
// - Bit 1 low runs zero-scale offset calibration; high runs full-scale gain.
// - Writing one to bit 0 launches calibration with current type and averaging.
// - Bit 0 clears itself when the calibration it launched completes.
// - Code 0111 selects nothing; 1000 to 1100 pick internal sources.
module adccal_ctrl
	import adccal_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	input  wire logic [7:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	input  wire logic                      conv_start,
	input  wire logic                      raw_valid,
	input  wire logic [ADCCAL_DW-1:0]      raw_data,
	input  wire logic                      samp_valid,
	input  wire logic                      cmp_high,
	input  wire logic [3:0]                chan_code,
	output logic      [ADCCAL_CH_EN_W-1:0] chan_en,
	output logic                           cal_run,
	output logic                           cal_gain,
	output logic      [ADCCAL_DW-1:0]      cal_trial,
	output logic                           corr_valid,
	output logic      [ADCCAL_DW-1:0]      corr_data,
	output logic                           adc_busy,
	output logic                           irq
);

	// Readings needed per bit decision
	function automatic logic [5:0] avg_count(input logic [1:0] sel);
		unique case (sel)
			2'b00: avg_count = ADCCAL_AVG_00;
			2'b01: avg_count = ADCCAL_AVG_01;
			2'b10: avg_count = ADCCAL_AVG_10;
			2'b11: avg_count = ADCCAL_AVG_11;
		endcase
	endfunction : avg_count

	// One-hot mask of a coefficient bit
	function automatic logic [ADCCAL_DW-1:0] bit_mask(input logic [3:0] idx);
		bit_mask = ADCCAL_DW'(1) << idx;
	endfunction : bit_mask

	// Channel code to one-hot select
	function automatic logic [ADCCAL_CH_EN_W-1:0] chan_decode(input logic [3:0] code);
		chan_decode = '0;
		if (code <= ADCCAL_CH_LAST_EXT)
			chan_decode[code] = 1'b1;
		else if (code >= ADCCAL_CH_TEMP && code <= ADCCAL_CH_VREF)
			chan_decode[4'(ADCCAL_EN_TEMP) + (code - ADCCAL_CH_TEMP)] = 1'b1;
	endfunction : chan_decode

	adccal_state_e        state;
	adccal_state_e        next_state;
	logic [6:1]           ctrl_cfg;
	logic                 cal_start;
	logic [1:0]           avg_run;
	logic [ADCCAL_DW-1:0] ofs_coeff;
	logic [ADCCAL_DW-1:0] gain_coeff;
	logic [3:0]           bit_idx;
	logic [5:0]           rd_cnt;
	logic [5:0]           ones_cnt;
	logic [1:0]           irq_stat;
	logic [1:0]           irq_mask;
	logic [1:0]           next_irq_stat;
	logic [1:0]           next_irq_mask;

	logic                 wr_ctrl;
	logic [5:0]           n_need;
	logic [6:0]           ones_total;
	logic                 keep_bit;
	logic                 last_read;
	logic                 cal_fin;
	logic                 conv_fin;
	logic                 launch_cal;
	logic [ADCCAL_DW-1:0] decided;
	logic [ADCCAL_DW-1:0] ofs_applied;
	logic [ADCCAL_DW-1:0] gain_used;
	logic [2*ADCCAL_DW-1:0] product;
	logic [ADCCAL_DW-1:0] corrected;

	// Decode of events and calibration steps
	assign wr_ctrl    = reg_wr && reg_addr == ADCCAL_CTRL_ADDR;
	assign n_need     = avg_count(avg_run);
	assign ones_total = {1'b0, ones_cnt} + {6'h00, cmp_high};
	assign keep_bit   = {ones_total, 1'b0} < {2'b00, n_need}; // Majority says not too high
	assign last_read  = state == ADCCAL_ST_CAL && samp_valid && rd_cnt == n_need - 6'd1;
	assign cal_fin    = last_read && bit_idx == 4'h0;
	assign conv_fin   = state == ADCCAL_ST_CONV && raw_valid;
	assign launch_cal = state == ADCCAL_ST_IDLE && !conv_start && cal_start;
	assign decided    = keep_bit ? cal_trial : (cal_trial & ~bit_mask(bit_idx));

	// Next state; conversion request outranks a pending calibration
	always_comb begin
		next_state = state;
		unique case (state)
			ADCCAL_ST_IDLE: begin
				if (conv_start)
					next_state = ADCCAL_ST_CONV;
				else if (cal_start)
					next_state = ADCCAL_ST_CAL;
			end
			ADCCAL_ST_CONV: begin
				if (raw_valid)
					next_state = ADCCAL_ST_IDLE;
			end
			ADCCAL_ST_CAL: begin
				if (cal_fin)
					next_state = ADCCAL_ST_IDLE;
			end
			default: next_state = ADCCAL_ST_IDLE;
		endcase
	end

	// State register and flopped status outputs
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state    <= ADCCAL_ST_IDLE;
			adc_busy <= 1'b0;
			cal_run  <= 1'b0;
		end else begin
			state    <= next_state;
			adc_busy <= next_state != ADCCAL_ST_IDLE;
			cal_run  <= next_state == ADCCAL_ST_CAL;
		end
	end

	// Configuration bits written by software
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			ctrl_cfg <= ADCCAL_CTRL_RESET[6:1];
		else if (wr_ctrl)
			ctrl_cfg <= reg_wdata[6:1];
	end

	// Start bit: set by a write of one, self-cleared on completion
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			cal_start <= ADCCAL_CTRL_RESET[ADCCAL_START_BIT];
		else if (cal_fin)
			cal_start <= 1'b0;
		else if (wr_ctrl && reg_wdata[ADCCAL_START_BIT])
			cal_start <= 1'b1;
	end

	// Successive search of the coefficient, one bit per averaged decision
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cal_trial <= '0;
			bit_idx   <= '0;
			rd_cnt    <= '0;
			ones_cnt  <= '0;
			cal_gain  <= 1'b0;
			avg_run   <= 2'b00;
		end else if (launch_cal) begin
			cal_trial <= ADCCAL_TRIAL_TOP;
			bit_idx   <= ADCCAL_TOP_BIT;
			rd_cnt    <= '0;
			ones_cnt  <= '0;
			cal_gain  <= ctrl_cfg[ADCCAL_TYPE_BIT];
			avg_run   <= ctrl_cfg[ADCCAL_AVG_HI_BIT:ADCCAL_AVG_LO_BIT];
		end else if (last_read) begin
			cal_trial <= decided | (bit_mask(bit_idx) >> 1);
			bit_idx   <= cal_fin ? 4'h0 : bit_idx - 4'h1;
			rd_cnt    <= '0;
			ones_cnt  <= '0;
		end else if (state == ADCCAL_ST_CAL && samp_valid) begin
			rd_cnt    <= rd_cnt + 6'd1;
			ones_cnt  <= ones_total[5:0];
		end
	end

	// Stored coefficients take the search result
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ofs_coeff  <= ADCCAL_OFS_RESET;
			gain_coeff <= ADCCAL_GAIN_RESET;
		end else if (cal_fin) begin
			if (cal_gain)
				gain_coeff <= decided;
			else
				ofs_coeff  <= decided;
		end
	end

	// Result correction: offset subtract, then gain scale with saturation
	always_comb begin
		if (ctrl_cfg[ADCCAL_OFS_BYP_BIT] || raw_data <= ofs_coeff)
			ofs_applied = ctrl_cfg[ADCCAL_OFS_BYP_BIT] ? raw_data : '0;
		else
			ofs_applied = raw_data - ofs_coeff;
		gain_used = ctrl_cfg[ADCCAL_GAIN_BYP_BIT] ? ADCCAL_GAIN_RESET : gain_coeff;
		product   = ofs_applied * gain_used;
		if (product[2*ADCCAL_DW-1])
			corrected = '1;
		else
			corrected = product[ADCCAL_GAIN_SHIFT +: ADCCAL_DW];
	end

	// Corrected result, one pulse per conversion
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			corr_valid <= 1'b0;
			corr_data  <= '0;
		end else begin
			corr_valid <= conv_fin;
			if (conv_fin)
				corr_data <= corrected;
		end
	end

	// Channel select decode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			chan_en <= '0;
		else
			chan_en <= chan_decode(chan_code);
	end

	// Sticky event flags; a new event wins over a write-one clear
	always_comb begin
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		if (reg_wr && reg_addr == ADCCAL_STAT_ADDR)
			next_irq_stat = irq_stat & ~reg_wdata[1:0];
		if (reg_wr && reg_addr == ADCCAL_MASK_ADDR)
			next_irq_mask = reg_wdata[1:0];
		next_irq_stat[ADCCAL_IRQ_CAL_BIT]  = next_irq_stat[ADCCAL_IRQ_CAL_BIT] | cal_fin;
		next_irq_stat[ADCCAL_IRQ_CONV_BIT] = next_irq_stat[ADCCAL_IRQ_CONV_BIT] | conv_fin;
	end

	// Interrupt registers and level output
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= ADCCAL_IRQ_RESET;
			irq_mask <= ADCCAL_IRQ_RESET;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq      <= |(next_irq_stat & next_irq_mask);
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else begin
			unique case (reg_addr)
				ADCCAL_CTRL_ADDR:    reg_rdata <= {adc_busy, ctrl_cfg, cal_start};
				ADCCAL_STAT_ADDR:    reg_rdata <= {6'h00, irq_stat};
				ADCCAL_MASK_ADDR:    reg_rdata <= {6'h00, irq_mask};
				ADCCAL_OFS_LO_ADDR:  reg_rdata <= ofs_coeff[7:0];
				ADCCAL_OFS_HI_ADDR:  reg_rdata <= {4'h0, ofs_coeff[11:8]};
				ADCCAL_GAIN_LO_ADDR: reg_rdata <= gain_coeff[7:0];
				ADCCAL_GAIN_HI_ADDR: reg_rdata <= {4'h0, gain_coeff[11:8]};
				default:             reg_rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// Launch and first trial of a calibration
	sequence cal_go_s;
		state == ADCCAL_ST_IDLE && cal_start && !conv_start;
	endsequence
	sequence cal_first_s;
		state == ADCCAL_ST_CAL && adc_busy && cal_trial == ADCCAL_TRIAL_TOP;
	endsequence

	cal_launch_a: assert property (cal_go_s |=> cal_first_s)
		else $error("calibration did not launch");
	busy_conv_a: assert property (state == ADCCAL_ST_IDLE && conv_start |=> adc_busy)
		else $error("busy not raised for conversion");
	busy_drop_a: assert property (conv_fin |=> !adc_busy ##1
		(adc_busy == ($past(cal_start) || $past(conv_start))))
		else $error("busy not released after conversion");
	start_clear_a: assert property (cal_fin |=> !cal_start && !adc_busy && !cal_run)
		else $error("start bit not cleared on completion");
	avg_decide_a: assert property (state == ADCCAL_ST_CAL && $past(state) == ADCCAL_ST_CAL
		&& $changed(cal_trial) |-> $past(rd_cnt) == $past(n_need) - 6'd1)
		else $error("bit decided before all readings");
	gain_update_a: assert property (cal_fin && cal_gain |=> gain_coeff == $past(decided)
		&& $stable(ofs_coeff))
		else $error("gain coefficient not updated");
	ofs_update_a: assert property (cal_fin && !cal_gain |=> ofs_coeff == $past(decided)
		&& $stable(gain_coeff))
		else $error("offset coefficient not updated");
	bypass_both_a: assert property (conv_fin && ctrl_cfg[ADCCAL_OFS_BYP_BIT]
		&& ctrl_cfg[ADCCAL_GAIN_BYP_BIT] |=> corr_valid && corr_data == $past(raw_data))
		else $error("bypassed result altered");
	chan_none_a: assert property (chan_code == 4'h7 |=> chan_en == '0)
		else $error("code 0111 selected a channel");
	chan_vref_a: assert property (chan_code == ADCCAL_CH_VREF |=> chan_en[ADCCAL_EN_VREF]
		&& $onehot(chan_en))
		else $error("reference not selected");
	irq_event_a: assert property (cal_fin && irq_mask[ADCCAL_IRQ_CAL_BIT]
		&& !(reg_wr && reg_addr == ADCCAL_MASK_ADDR) |=> irq && irq_stat[ADCCAL_IRQ_CAL_BIT])
		else $error("calibration event not flagged");

endmodule : adccal_ctrl

`default_nettype wire

// File: design/adccal_pkg.sv
package adccal_pkg;

	// Register map
	localparam logic [7:0] ADCCAL_CTRL_ADDR    = 8'hf5;
	localparam logic [7:0] ADCCAL_STAT_ADDR    = 8'hf6;
	localparam logic [7:0] ADCCAL_MASK_ADDR    = 8'hf7;
	localparam logic [7:0] ADCCAL_OFS_LO_ADDR  = 8'hf8;
	localparam logic [7:0] ADCCAL_OFS_HI_ADDR  = 8'hf9;
	localparam logic [7:0] ADCCAL_GAIN_LO_ADDR = 8'hfa;
	localparam logic [7:0] ADCCAL_GAIN_HI_ADDR = 8'hfb;

	// Control register fields
	localparam int ADCCAL_BUSY_BIT     = 7;
	localparam int ADCCAL_GAIN_BYP_BIT = 6;
	localparam int ADCCAL_AVG_HI_BIT   = 5;
	localparam int ADCCAL_AVG_LO_BIT   = 4;
	localparam int ADCCAL_OFS_BYP_BIT  = 3;
	localparam int ADCCAL_MODE_BIT     = 2;
	localparam int ADCCAL_TYPE_BIT     = 1;
	localparam int ADCCAL_START_BIT    = 0;
	localparam logic [7:0] ADCCAL_CTRL_RESET = 8'h00;

	// Averaging counts per bit decision
	localparam logic [5:0] ADCCAL_AVG_00 = 6'd15;
	localparam logic [5:0] ADCCAL_AVG_01 = 6'd1;
	localparam logic [5:0] ADCCAL_AVG_10 = 6'd31;
	localparam logic [5:0] ADCCAL_AVG_11 = 6'd63;

	// Interrupt status bits
	localparam int ADCCAL_IRQ_CAL_BIT  = 0;
	localparam int ADCCAL_IRQ_CONV_BIT = 1;
	localparam logic [1:0] ADCCAL_IRQ_RESET = 2'h0;

	// Coefficients: data width, reset values, gain scaling
	localparam int ADCCAL_DW = 12;
	localparam logic [11:0] ADCCAL_OFS_RESET  = 12'h000;
	localparam logic [11:0] ADCCAL_GAIN_RESET = 12'h800;
	localparam logic [11:0] ADCCAL_TRIAL_TOP  = 12'h800;
	localparam logic [3:0]  ADCCAL_TOP_BIT    = 4'hb;
	localparam int ADCCAL_GAIN_SHIFT = 11;

	// Channel codes and one-hot select positions
	localparam logic [3:0] ADCCAL_CH_LAST_EXT = 4'h5;
	localparam logic [3:0] ADCCAL_CH_TEMP     = 4'h8;
	localparam logic [3:0] ADCCAL_CH_VREF     = 4'hc;
	localparam int ADCCAL_CH_EN_W   = 11;
	localparam int ADCCAL_EN_TEMP   = 6;
	localparam int ADCCAL_EN_VREF   = 10;

	typedef enum logic [1:0] {
		ADCCAL_ST_IDLE = 2'b00,
		ADCCAL_ST_CONV = 2'b01,
		ADCCAL_ST_CAL  = 2'b10
	} adccal_state_e;

endpackage : adccal_pkg
